// >>> design/ttl_pkg.sv
// Overview of operation
// - trigger write compares low nibble against each channel's match value; only matches act
// - a match starts the channel's message and, if enabled, its cycle timer at once
// - trigger writes are broadcast: accepted whatever the device address on the bus
// - trigger bits 7:4 are unused; only bits 3:0 count, register is write-only
// - threshold bit clear selects type 1 thresholds, set selects type 2/3
// - direction bit set enables current source, clear enables current sink
// - level field: 00 off, 01 5mA, 10 2mA, 11 150uA
// - low-side bit set gives low-side switching, clear high-side; ignored in push-pull
// - push-pull bit set drives push-pull, clear drives open-drain
// - driver-off bit set puts line pin in high impedance, clear enables driver
// - filter bit enables a receiver glitch filter of about 1.3us
// - channel B has its own identical line setup register
// - cycle timer starts on a match only when that channel's timer enable is set
package ttl_pkg;

	localparam int          CLK_PERIOD_PS = 25000;
	localparam int          FILT_TIME_PS  = 1300000;
	localparam int          FILT_CYC_INT  = (FILT_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam logic [5:0]  FILT_CYC      = 6'(FILT_CYC_INT);

	localparam logic [4:0]  ADDR_TRIGGER  = 5'h0F;
	localparam logic [4:0]  ADDR_CFG_A    = 5'h10;
	localparam logic [4:0]  ADDR_CFG_B    = 5'h11;

	localparam int          CMD_RD_BIT    = 7;
	localparam int          CMD_DEV_HI    = 6;
	localparam int          CMD_DEV_LO    = 5;
	localparam int          CMD_REG_HI    = 4;
	localparam logic [3:0]  LAST_BIT      = 4'h7;

	localparam logic [3:0]  TRIG_RESET    = 4'h0;
	localparam logic [7:0]  CFG_RESET     = 8'h00;
	localparam logic [7:0]  READ_NONE     = 8'h00;

	localparam logic [1:0]  LVL_OFF       = 2'h0;
	localparam logic [1:0]  LVL_5MA       = 2'h1;
	localparam logic [1:0]  LVL_2MA       = 2'h2;
	localparam logic [1:0]  LVL_150UA     = 2'h3;

	typedef enum logic [1:0] {PH_IDLE, PH_CMD, PH_DATA, PH_DONE} ttl_phase_t;

	// line setup register, bit 7 down to bit 0
	typedef struct packed {
		logic       high_threshold_sel;
		logic       current_dir_sel;
		logic [1:0] current_level;
		logic       low_side_sel;
		logic       totem_pole_sel;
		logic       driver_off;
		logic       glitch_filter_on;
	} ttl_cfg_t;

	typedef struct packed {
		logic cs_n;
		logic sclk;
		logic mosi;
	} ttl_spi_t;

endpackage : ttl_pkg

// >>> design/ttl_trigger_line_cfg.sv
module ttl_trigger_line_cfg (
	input  wire logic              SYS_CLK,
	input  wire logic              RST_N,
	input  wire ttl_pkg::ttl_spi_t SPI_IN,
	input  wire logic [1:0]        CHIP_SEL_ADDR,
	output logic                   MISO_O,
	output logic                   MISO_OE,
	input  wire logic [3:0]        CHAN_A_TRIGGER_MATCH_VALUE,
	input  wire logic [3:0]        CHAN_B_TRIGGER_MATCH_VALUE,
	input  wire logic              CHAN_A_PERIOD_TIMER_ON,
	input  wire logic              CHAN_B_PERIOD_TIMER_ON,
	input  wire logic              CHAN_A_TX_DATA,
	input  wire logic              CHAN_B_TX_DATA,
	input  wire logic              CHAN_A_LINE_PIN_I,
	input  wire logic              CHAN_B_LINE_PIN_I,
	output logic                   CHAN_A_LINE_PIN_O,
	output logic                   CHAN_A_LINE_PIN_OE,
	output logic                   CHAN_B_LINE_PIN_O,
	output logic                   CHAN_B_LINE_PIN_OE,
	output logic                   CHAN_A_RX_FILTERED,
	output logic                   CHAN_B_RX_FILTERED,
	output logic                   CHAN_A_SOURCE_ON,
	output logic                   CHAN_A_SINK_ON,
	output logic                   CHAN_B_SOURCE_ON,
	output logic                   CHAN_B_SINK_ON,
	output ttl_pkg::ttl_cfg_t      CHAN_A_LINE_SETUP,
	output ttl_pkg::ttl_cfg_t      CHAN_B_LINE_SETUP,
	output logic                   CHAN_A_START_MSG,
	output logic                   CHAN_B_START_MSG,
	output logic                   CHAN_A_START_TIMER,
	output logic                   CHAN_B_START_TIMER
);

	typedef struct packed {
		ttl_pkg::ttl_phase_t      phase;
		logic                     sclk_prev;
		logic [3:0]               bit_cnt;
		logic [7:0]               cmd;
		logic [7:0]               shin;
		logic [7:0]               shout;
		logic                     miso;
		logic                     miso_oe;
		logic [3:0]               trig;
		ttl_pkg::ttl_cfg_t [1:0]  cfg;
		logic [1:0]               start_msg;
		logic [1:0]               start_tmr;
		logic [1:0]               pin_o;
		logic [1:0]               pin_oe;
		logic [1:0]               src_on;
		logic [1:0]               sink_on;
		logic [1:0]               rx_filt;
		logic [1:0][5:0]          fcnt;
	} ttl_state_t;

	ttl_state_t q;
	ttl_state_t d;

	logic [1:0][3:0] match_val;
	logic [1:0]      tmr_on;
	logic [1:0]      tx_data;
	logic [1:0]      rx_raw;

	assign match_val = {CHAN_B_TRIGGER_MATCH_VALUE, CHAN_A_TRIGGER_MATCH_VALUE};
	assign tmr_on    = {CHAN_B_PERIOD_TIMER_ON, CHAN_A_PERIOD_TIMER_ON};
	assign tx_data   = {CHAN_B_TX_DATA, CHAN_A_TX_DATA};
	assign rx_raw    = {CHAN_B_LINE_PIN_I, CHAN_A_LINE_PIN_I};

	////////////////////////////////////////////////////////////////////////////////
	// helpers

	// returns {pin level, pin enable}
	function automatic logic [1:0] drive_line(input ttl_pkg::ttl_cfg_t c, input logic tx);
		logic [1:0] r;
		r = 2'h0;
		if (c.driver_off) begin
			r = 2'h0;
		end else if (c.totem_pole_sel) begin
			r = {tx, 1'b1};
		end else if (c.low_side_sel) begin
			r = {1'b0, tx};
		end else begin
			r = {1'b1, tx};
		end
		return r;
	endfunction : drive_line

	// returns {filtered level, count}
	function automatic logic [6:0] filter_step(input logic on, input logic raw, input logic flt,
		input logic [5:0] cnt);
		logic [6:0] r;
		r = {raw, 6'h00};
		if (on && raw != flt) begin
			if (cnt == ttl_pkg::FILT_CYC - 6'h01) begin
				r = {raw, 6'h00};
			end else begin
				r = {flt, cnt + 6'h01};
			end
		end else if (on) begin
			r = {flt, 6'h00};
		end
		return r;
	endfunction : filter_step

	function automatic logic [7:0] read_data(input logic [4:0] a, input ttl_pkg::ttl_cfg_t [1:0] c);
		logic [7:0] r;
		r = ttl_pkg::READ_NONE;
		case (a)
			ttl_pkg::ADDR_CFG_A: r = c[0];
			ttl_pkg::ADDR_CFG_B: r = c[1];
			default:             r = ttl_pkg::READ_NONE;
		endcase
		return r;
	endfunction : read_data

	////////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		logic       rise;
		logic       fall;
		logic       dev_hit;
		logic [7:0] nb;
		logic [6:0] fs;
		rise    = SPI_IN.sclk & ~q.sclk_prev;
		fall    = ~SPI_IN.sclk & q.sclk_prev;
		dev_hit = q.cmd[ttl_pkg::CMD_DEV_HI:ttl_pkg::CMD_DEV_LO] == CHIP_SEL_ADDR;
		nb      = 8'h00;
		fs      = 7'h00;
		d           = q;
		d.sclk_prev = SPI_IN.sclk;
		d.start_msg = 2'h0;
		d.start_tmr = 2'h0;
		case (q.phase)
			ttl_pkg::PH_IDLE: begin
				d.bit_cnt = 4'h0;
				d.miso_oe = 1'b0;
				if (!SPI_IN.cs_n) begin
					d.phase = ttl_pkg::PH_CMD;
				end
			end
			ttl_pkg::PH_CMD: begin
				if (SPI_IN.cs_n) begin
					d.phase = ttl_pkg::PH_IDLE;
				end else if (rise) begin
					nb        = {q.cmd[6:0], SPI_IN.mosi};
					d.cmd     = nb;
					d.bit_cnt = q.bit_cnt + 4'h1;
					if (q.bit_cnt == ttl_pkg::LAST_BIT) begin
						d.phase   = ttl_pkg::PH_DATA;
						d.bit_cnt = 4'h0;
						// only the addressed device answers a read
						if (nb[ttl_pkg::CMD_RD_BIT] && nb[ttl_pkg::CMD_DEV_HI:ttl_pkg::CMD_DEV_LO] == CHIP_SEL_ADDR) begin
							d.shout   = read_data(nb[ttl_pkg::CMD_REG_HI:0], q.cfg);
							d.miso_oe = 1'b1;
						end
					end
				end
			end
			ttl_pkg::PH_DATA: begin
				if (SPI_IN.cs_n) begin
					d.phase = ttl_pkg::PH_IDLE;
				end else if (rise) begin
					nb        = {q.shin[6:0], SPI_IN.mosi};
					d.shin    = nb;
					d.bit_cnt = q.bit_cnt + 4'h1;
					if (q.bit_cnt == ttl_pkg::LAST_BIT) begin
						d.phase = ttl_pkg::PH_DONE;
						if (!q.cmd[ttl_pkg::CMD_RD_BIT]) begin
							case (q.cmd[ttl_pkg::CMD_REG_HI:0])
								ttl_pkg::ADDR_TRIGGER: begin
									d.trig = nb[3:0];
									for (int ch = 0; ch < 2; ch++) begin
										if (nb[3:0] == match_val[ch]) begin
											d.start_msg[ch] = 1'b1;
											d.start_tmr[ch] = tmr_on[ch];
										end
									end
								end
								ttl_pkg::ADDR_CFG_A: begin
									if (dev_hit) begin
										d.cfg[0] = nb;
									end
								end
								ttl_pkg::ADDR_CFG_B: begin
									if (dev_hit) begin
										d.cfg[1] = nb;
									end
								end
								default: begin
								end
							endcase
						end
					end
				end
			end
			ttl_pkg::PH_DONE: begin
				if (SPI_IN.cs_n) begin
					d.phase   = ttl_pkg::PH_IDLE;
					d.miso_oe = 1'b0;
				end
			end
			default: begin
				d.phase = ttl_pkg::PH_IDLE;
			end
		endcase
		// shift read data out on falling edges
		if (fall && q.phase != ttl_pkg::PH_IDLE && q.phase != ttl_pkg::PH_CMD) begin
			d.miso  = q.shout[7];
			d.shout = {q.shout[6:0], 1'b0};
		end
		for (int ch = 0; ch < 2; ch++) begin
			{d.pin_o[ch], d.pin_oe[ch]} = drive_line(q.cfg[ch], tx_data[ch]);
			d.src_on[ch]  = q.cfg[ch].current_dir_sel & (q.cfg[ch].current_level != ttl_pkg::LVL_OFF);
			d.sink_on[ch] = ~q.cfg[ch].current_dir_sel & (q.cfg[ch].current_level != ttl_pkg::LVL_OFF);
			fs            = filter_step(q.cfg[ch].glitch_filter_on, rx_raw[ch], q.rx_filt[ch], q.fcnt[ch]);
			d.rx_filt[ch] = fs[6];
			d.fcnt[ch]    = fs[5:0];
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			q       <= '0;
			q.trig  <= ttl_pkg::TRIG_RESET;
			q.cfg   <= {ttl_pkg::CFG_RESET, ttl_pkg::CFG_RESET};
		end else begin
			q <= d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs

	assign MISO_O             = q.miso;
	assign MISO_OE            = q.miso_oe;
	assign CHAN_A_LINE_PIN_O  = q.pin_o[0];
	assign CHAN_A_LINE_PIN_OE = q.pin_oe[0];
	assign CHAN_B_LINE_PIN_O  = q.pin_o[1];
	assign CHAN_B_LINE_PIN_OE = q.pin_oe[1];
	assign CHAN_A_RX_FILTERED = q.rx_filt[0];
	assign CHAN_B_RX_FILTERED = q.rx_filt[1];
	assign CHAN_A_SOURCE_ON   = q.src_on[0];
	assign CHAN_A_SINK_ON     = q.sink_on[0];
	assign CHAN_B_SOURCE_ON   = q.src_on[1];
	assign CHAN_B_SINK_ON     = q.sink_on[1];
	assign CHAN_A_LINE_SETUP  = q.cfg[0];
	assign CHAN_B_LINE_SETUP  = q.cfg[1];
	assign CHAN_A_START_MSG   = q.start_msg[0];
	assign CHAN_B_START_MSG   = q.start_msg[1];
	assign CHAN_A_START_TIMER = q.start_tmr[0];
	assign CHAN_B_START_TIMER = q.start_tmr[1];

	////////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RST_N);

	sequence s_write_done(logic [4:0] a);
		q.phase == ttl_pkg::PH_DONE && $past(q.phase) == ttl_pkg::PH_DATA && !q.cmd[ttl_pkg::CMD_RD_BIT]
			&& q.cmd[ttl_pkg::CMD_REG_HI:0] == a;
	endsequence

	a_trig_broadcast: assert property (s_write_done(ttl_pkg::ADDR_TRIGGER) |-> q.trig == q.shin[3:0])
		else $error("trigger write not taken");
	a_match_only: assert property (q.start_msg[0] |-> q.trig == $past(CHAN_A_TRIGGER_MATCH_VALUE))
		else $error("start without matching trigger");
	a_match_starts: assert property (s_write_done(ttl_pkg::ADDR_TRIGGER) ##0
		(q.shin[3:0] == $past(CHAN_B_TRIGGER_MATCH_VALUE)) |-> q.start_msg[1] ##1 !q.start_msg[1])
		else $error("matching trigger did not pulse start");
	a_timer_gate: assert property (q.start_tmr[0] |-> q.start_msg[0] && $past(CHAN_A_PERIOD_TIMER_ON))
		else $error("timer started while disabled");
	a_chan_b_write: assert property (s_write_done(ttl_pkg::ADDR_CFG_B) ##0
		(q.cmd[ttl_pkg::CMD_DEV_HI:ttl_pkg::CMD_DEV_LO] == $past(CHIP_SEL_ADDR)) |-> q.cfg[1] == q.shin)
		else $error("channel b setup not written");
	a_read_stable: assert property ((q.phase == ttl_pkg::PH_DONE && q.cmd[ttl_pkg::CMD_RD_BIT]) |-> $stable(q.cfg))
		else $error("read altered setup");
	a_driver_hiz: assert property (q.cfg[0].driver_off |=> !CHAN_A_LINE_PIN_OE)
		else $error("disabled driver still enabled");
	a_totem_drive: assert property ((!q.cfg[1].driver_off && q.cfg[1].totem_pole_sel) |=>
		CHAN_B_LINE_PIN_OE && CHAN_B_LINE_PIN_O == $past(CHAN_B_TX_DATA))
		else $error("push-pull drive wrong");
	a_low_side: assert property ((!q.cfg[0].driver_off && !q.cfg[0].totem_pole_sel && q.cfg[0].low_side_sel
		&& CHAN_A_TX_DATA) |=> CHAN_A_LINE_PIN_OE && !CHAN_A_LINE_PIN_O)
		else $error("low-side drive wrong");
	a_source_sel: assert property ((q.cfg[0].current_dir_sel && q.cfg[0].current_level != ttl_pkg::LVL_OFF) |=>
		CHAN_A_SOURCE_ON && !CHAN_A_SINK_ON)
		else $error("source not selected");
	a_level_off: assert property ((q.cfg[1].current_level == ttl_pkg::LVL_OFF) |=> !CHAN_B_SOURCE_ON && !CHAN_B_SINK_ON)
		else $error("current on at level off");
	a_filter_hold: assert property (($changed(q.rx_filt[0]) && $past(q.cfg[0].glitch_filter_on))
		|-> $past(q.fcnt[0]) == ttl_pkg::FILT_CYC - 6'h01)
		else $error("filter passed short glitch");

endmodule : ttl_trigger_line_cfg

// >>> testbench/ttl_spi_host.sv
module ttl_spi_host (
	input  wire logic         SYS_CLK,
	input  wire logic         MISO_I,
	output ttl_pkg::ttl_spi_t SPI_OUT
);
	timeunit 1ns;
	timeprecision 1ps;
	logic cs_n   = 1'b1;
	logic sclk   = 1'b0;
	logic mosi_q = 1'b0;
	logic idle_q = 1'b0;
	// data line shows a changing pattern while deselected
	always @(negedge SYS_CLK) begin
		idle_q <= ~idle_q;
	end
	assign SPI_OUT = {cs_n, sclk, cs_n ? idle_q : mosi_q};
	task automatic hold(input int n);
		repeat (n) @(negedge SYS_CLK);
	endtask : hold
	// msb first, sclk low and high two cycles each; short nbits aborts the frame
	task automatic xfer(input logic [15:0] word, input int nbits, output logic [7:0] rd);
		rd = 8'h00;
		hold(1);
		cs_n = 1'b0;
		for (int i = 15; i >= 16 - nbits; i--) begin
			hold(1);
			mosi_q = word[i];
			hold(1);
			if (i < 8) rd[i] = MISO_I;
			sclk = 1'b1;
			hold(2);
			sclk = 1'b0;
		end
		hold(2);
		cs_n = 1'b1;
		hold(2);
	endtask : xfer
endmodule : ttl_spi_host

// >>> testbench/ttl_trigger_line_cfg_bench.sv
module ttl_trigger_line_cfg_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic              clk     = 1'b0;
	logic              rst_n   = 1'b0;
	logic [3:0]        match_a = 4'h0, match_b = 4'h0;
	logic              tmr_a   = 1'b0, tmr_b = 1'b0, tx = 1'b0, ext_a = 1'b0;
	logic              miso, miso_oe, a_o, a_oe, b_o, b_oe, rx_a, rx_b, src_a, snk_a, src_b, snk_b;
	logic              msg_a, msg_b, tm_a, tm_b;
	ttl_pkg::ttl_spi_t spi;
	ttl_pkg::ttl_cfg_t cfg_a, cfg_b;
	int                n_fail  = 0, checks = 0, n_ma = 0, n_ta = 0, n_mb = 0, n_tb = 0, n_oe = 0;
	initial forever #12.5 clk = ~clk;
	always @(negedge clk) begin
		n_ma += msg_a;
		n_ta += tm_a;
		n_mb += msg_b;
		n_tb += tm_b;
		n_oe += miso_oe;
	end
	// data line pulled up while no device drives it
	ttl_spi_host i_ttl_spi_host (.SYS_CLK(clk), .MISO_I(miso_oe ? miso : 1'b1), .SPI_OUT(spi));
	ttl_trigger_line_cfg i_ttl_trigger_line_cfg (
		.SYS_CLK(clk), .RST_N(rst_n), .SPI_IN(spi), .CHIP_SEL_ADDR(2'h1),
		.MISO_O(miso), .MISO_OE(miso_oe),
		.CHAN_A_TRIGGER_MATCH_VALUE(match_a), .CHAN_B_TRIGGER_MATCH_VALUE(match_b),
		.CHAN_A_PERIOD_TIMER_ON(tmr_a), .CHAN_B_PERIOD_TIMER_ON(tmr_b),
		.CHAN_A_TX_DATA(tx), .CHAN_B_TX_DATA(tx),
		.CHAN_A_LINE_PIN_I(a_oe ? a_o : ext_a), .CHAN_B_LINE_PIN_I(b_oe ? b_o : 1'b0),
		.CHAN_A_LINE_PIN_O(a_o), .CHAN_A_LINE_PIN_OE(a_oe),
		.CHAN_B_LINE_PIN_O(b_o), .CHAN_B_LINE_PIN_OE(b_oe),
		.CHAN_A_RX_FILTERED(rx_a), .CHAN_B_RX_FILTERED(rx_b),
		.CHAN_A_SOURCE_ON(src_a), .CHAN_A_SINK_ON(snk_a),
		.CHAN_B_SOURCE_ON(src_b), .CHAN_B_SINK_ON(snk_b),
		.CHAN_A_LINE_SETUP(cfg_a), .CHAN_B_LINE_SETUP(cfg_b),
		.CHAN_A_START_MSG(msg_a), .CHAN_B_START_MSG(msg_b),
		.CHAN_A_START_TIMER(tm_a), .CHAN_B_START_TIMER(tm_b)
	);
	////////////////////////////////////////////////////////////////////////////////
	task automatic end_of_test();
		if (n_fail == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : end_of_test
	task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp8
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc
	task automatic wr(input logic [7:0] cmd, input logic [7:0] data);
		logic [7:0] r;
		i_ttl_spi_host.xfer({cmd, data}, 16, r);
	endtask : wr
	task automatic rd(input logic [7:0] cmd, input logic [7:0] exp, input string what);
		logic [7:0] r;
		i_ttl_spi_host.xfer({cmd, 8'h00}, 16, r);
		cmp8(what, exp, r);
	endtask : rd
	task automatic pulses(input int ma, input int ta, input int mb, input int tb);
		cmp8("msg_a", 8'(ma), 8'(n_ma));
		cmp8("timer_a", 8'(ta), 8'(n_ta));
		cmp8("msg_b", 8'(mb), 8'(n_mb));
		cmp8("timer_b", 8'(tb), 8'(n_tb));
	endtask : pulses
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		cmp8("setup_a", 8'h00, cfg_a);
		cmp8("setup_b", 8'h00, cfg_b);
		rd(8'hB0, 8'h00, "read_a");
		rd(8'hB1, 8'h00, "read_b");
	endtask : t_reset
	task automatic t_regs();
		logic [7:0] r;
		int         oe0;
		wr(8'h30, 8'hA5);
		wr(8'h31, 8'h5A);
		rd(8'hB0, 8'hA5, "read_a");
		rd(8'hB0, 8'hA5, "reread_a");
		rd(8'hB1, 8'h5A, "read_b");
		cmp8("setup_a", 8'hA5, cfg_a);
		cmp8("setup_b", 8'h5A, cfg_b);
		wr(8'h10, 8'hFF);
		i_ttl_spi_host.xfer(16'h3000, 10, r);
		cmp8("setup_a", 8'hA5, cfg_a);
		oe0 = n_oe;
		rd(8'h90, 8'hFF, "read_other_addr");
		cmp8("miso_oe_other_addr", 8'(oe0), 8'(n_oe));
	endtask : t_regs
	task automatic t_trig();
		match_a = 4'h3;
		match_b = 4'h5;
		tmr_a   = 1'b1;
		wr(8'h6F, 8'hF3);
		pulses(1, 1, 0, 0);
		wr(8'h0F, 8'h05);
		pulses(1, 1, 1, 0);
		tmr_b = 1'b1;
		wr(8'h2F, 8'h05);
		pulses(1, 1, 2, 1);
		wr(8'h0F, 8'h09);
		pulses(1, 1, 2, 1);
		rd(8'hAF, 8'h00, "read_trigger");
	endtask : t_trig
	task automatic t_current();
		for (int k = 0; k < 8; k++) begin
			wr(8'h30, 8'(k) << 4);
			wr(8'h31, 8'(k) << 4);
			cyc(3);
			cmp8("source_a", 8'(k >= 5), src_a);
			cmp8("sink_a", 8'(k >= 1 && k <= 3), snk_a);
			cmp8("source_b", 8'(k >= 5), src_b);
			cmp8("sink_b", 8'(k >= 1 && k <= 3), snk_b);
		end
	endtask : t_current
	task automatic t_driver();
		logic [3:0] md[5] = '{4'h2, 4'h4, 4'hC, 4'h0, 4'h8};
		logic       eoe;
		logic       eo;
		for (int m = 0; m < 5; m++) begin
			wr(8'h30, {4'h0, md[m]});
			wr(8'h31, {4'h0, md[m]});
			for (int t = 0; t < 2; t++) begin
				tx = t[0];
				cyc(3);
				eoe = md[m][1] ? 1'b0 : (md[m][2] ? 1'b1 : tx);
				eo  = md[m][2] ? tx : !md[m][3];
				cmp8("pin_oe", 8'(eoe), a_oe);
				cmp8("pin_oe_b", 8'(eoe), b_oe);
				if (eoe) cmp8("pin_o", 8'(eo), a_o);
				if (eoe) cmp8("pin_o_b", 8'(eo), b_o);
				cmp8("rx_b", 8'(eoe & eo), rx_b);
			end
		end
		wr(8'h30, 8'h04);
		tx = 1'b0;
		cyc(3);
		cmp8("pin_push_pull", 8'h01, {6'h00, a_o, a_oe});
	endtask : t_driver
	task automatic t_filter();
		wr(8'h30, 8'h03);
		ext_a = 1'b1;
		cyc(20);
		ext_a = 1'b0;
		cyc(60);
		cmp8("rx_glitch", 8'h00, rx_a);
		ext_a = 1'b1;
		cyc(60);
		cmp8("rx_long", 8'h01, rx_a);
		wr(8'h30, 8'h02);
		ext_a = 1'b0;
		cyc(3);
		cmp8("rx_raw", 8'h00, rx_a);
	endtask : t_filter
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (100000) @(posedge clk);
		n_fail++;
		end_of_test();
	end
	initial begin
		cyc(6);
		rst_n = 1'b1;
		cyc(2);
		t_reset();
		t_regs();
		t_trig();
		t_current();
		t_driver();
		t_filter();
		end_of_test();
	end
endmodule : ttl_trigger_line_cfg_bench
